// ---- hdl/adc_sequence_buffer_control.sv ----
// What this block does
// - reference code picks high and low references
// - offset calibration ties both inputs low reference
// - without calibration, inputs follow channel or scan
// - scan bit steps inputs; clear means none
// - fill status shows half being filled
// - interrupt every n+1 finished sequences
// - buffer mode: two halves or one
// - alternate mode: A first, then B, A
// - alternate off: always setting A
// - upper and unassigned bits read zero
//
// Implementation choices: the placing of the registers and register access over APB.
`include "adc_seq_defines.svh"
`default_nettype none

module adc_sequence_buffer_control #(
   parameter int DEPTH = 16,
   parameter int AW    = 4,
   parameter int PAW   = 12
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [PAW-1:0]        paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  seq_done,
   input  wire logic                  conv_done,
   output adc_seq_pkg::ref_high_t     ref_high,
   output adc_seq_pkg::ref_low_t      ref_low,
   output adc_seq_pkg::route_t        input_route,
   output logic      [AW-1:0]         scan_index,
   output logic                       mux_b_select,
   output logic      [AW-1:0]         buf_addr,
   output logic                       fill_status,
   output logic                       irq
);
   import adc_seq_pkg::*;

   // is this offset one of ours
   function automatic logic is_mapped(input logic [PAW-1:0] a);
      is_mapped = (a == `CTL_OFFSET) || (a == `STATUS_OFFSET) ||
                  (a == `MASK_OFFSET) || (a == `SCAN_OFFSET);
   endfunction : is_mapped

   // next set scan bit after cur, wrapping; zero when mask empty
   function automatic logic [AW-1:0] next_scan(
      input logic [DEPTH-1:0] mask,
      input logic [AW-1:0]    cur
   );
      logic [AW-1:0] idx;
      logic          found;
      next_scan = '0;
      found     = 1'b0;
      for (int i = 1; i <= DEPTH; i++) begin
         idx = cur + i[AW-1:0];
         if (!found && mask[idx]) begin
            next_scan = idx;
            found     = 1'b1;
         end
      end
   endfunction : next_scan

   // ---------------- bus side ----------------
   logic [15:0]      ctl;           // writable control fields
   logic [DEPTH-1:0] scan_mask;     // inputs visited while scanning
   logic [1:0]       irq_status;    // sticky events
   logic [1:0]       irq_mask;      // enables onto irq

   wire access   = psel && penable;              // access phase
   wire first    = access && !pready;            // answer being built
   wire mapped   = is_mapped(paddr);
   wire wr_fire  = access && pready && pwrite;   // write commit edge
   wire ctl_wr   = wr_fire && (paddr == `CTL_OFFSET);
   wire stat_wr  = wr_fire && (paddr == `STATUS_OFFSET);
   wire mask_wr  = wr_fire && (paddr == `MASK_OFFSET);
   wire scan_wr  = wr_fire && (paddr == `SCAN_OFFSET);

   // control fields as named wires
   wire [2:0] ref_code  = ctl[`REF_MSB:`REF_LSB];
   wire       offset_calibration_select_en = ctl[`OFFSET_CALIBRATION_SELECT_BIT];
   wire       scan_en   = ctl[`SCAN_BIT];
   wire [3:0] spi_limit = ctl[`SPI_MSB:`SPI_LSB];
   wire       split_en  = ctl[`BUFFER_MODE_SELECT_BIT];
   wire       alt_en    = ctl[`ALT_BIT];

   // control read view: writable bits plus live fill status
   wire [15:0] ctl_view = (ctl & `CTL_WMASK) |
                          {8'h00, fill_status, 7'h00};

   // read mux; everything above the low half stays zero
   wire [31:0] rd_ctl  = {16'h0000, ctl_view};
   wire [31:0] rd_stat = {30'h0, irq_status};
   wire [31:0] rd_mask = {30'h0, irq_mask};
   wire [31:0] rd_scan = {{(32-DEPTH){1'b0}}, scan_mask};
   wire [31:0] rd_data = (paddr == `CTL_OFFSET)    ? rd_ctl  :
                         (paddr == `STATUS_OFFSET) ? rd_stat :
                         (paddr == `MASK_OFFSET)   ? rd_mask :
                         (paddr == `SCAN_OFFSET)   ? rd_scan :
                                                     32'h0000_0000;

   // one wait state: ready rises on the second access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= first;
         pslverr <= first && !mapped;
         prdata  <= (first && !pwrite) ? rd_data : 32'h0000_0000;
      end
   end

   // software-written registers; read-only and unused bits never stored
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl       <= `CTL_RESET;
         scan_mask <= `SCAN_RESET;
         irq_mask  <= `IRQ_RESET;
      end else begin
         if (ctl_wr) begin
            ctl <= pwdata[15:0] & `CTL_WMASK;
         end
         if (scan_wr) begin
            scan_mask <= pwdata[DEPTH-1:0];
         end
         if (mask_wr) begin
            irq_mask <= pwdata[1:0];
         end
      end
   end

   // ---------------- sequence counting and buffer ----------------
   logic count_done;   // registered once-per-n+1 pulse
   logic buf_wrap;     // pointer ran past its region

   // a control write restarts counting so a new limit starts clean
   seq_interrupt_counter #(
      .CW       (4)
   ) u_count (
      .clk      (clk),
      .rst      (rst),
      .clear    (ctl_wr),
      .seq_done (seq_done),
      .limit    (spi_limit),
      .done     (count_done)
   );

   // half switching follows the count, never the address itself
   result_pointer #(
      .DEPTH       (DEPTH),
      .AW          (AW)
   ) u_ptr (
      .clk         (clk),
      .rst         (rst),
      .clear       (ctl_wr),
      .conv_done   (conv_done),
      .split       (split_en),
      .switch_half (count_done),
      .addr        (buf_addr),
      .fill_high   (fill_status),
      .wrap        (buf_wrap)
   );

   // ---------------- analog steering ----------------
   // reference decode: 1xx and 000 fall back to supply and ground
   wire high_pin = !ref_code[2] && ref_code[0];
   wire low_pin  = !ref_code[2] && ref_code[1];

   // calibration overrides channel and scan routing
   wire route_t next_route = offset_calibration_select_en ? ROUTE_LOW_REF :
                             scan_en   ? ROUTE_SCAN    :
                                         ROUTE_CHANNEL;

   // registered so the analog switches never see a bus glitch
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_high    <= HIGH_FROM_SUPPLY;
         ref_low     <= LOW_FROM_GROUND;
         input_route <= ROUTE_CHANNEL;
      end else begin
         ref_high    <= high_pin ? HIGH_FROM_PIN : HIGH_FROM_SUPPLY;
         ref_low     <= low_pin  ? LOW_FROM_PIN  : LOW_FROM_GROUND;
         input_route <= next_route;
      end
   end

   // restart points: a control write or an interrupt boundary
   wire             restart   = ctl_wr || count_done;
   // a control write lands on this edge, so follow the bit being written;
   // otherwise switching scan on would start from input 0 regardless
   wire             scan_on    = ctl_wr ? pwdata[`SCAN_BIT] : scan_en;
   wire [AW-1:0]    scan_first = next_scan(scan_mask, {AW{1'b1}});
   wire [AW-1:0]    scan_step  = next_scan(scan_mask, scan_index);

   // scan index: idle at zero unless scanning is on
   always_ff @(posedge clk) begin
      if (rst) begin
         scan_index <= '0;
      end else if (!scan_on) begin
         scan_index <= '0;
      end else if (restart) begin
         scan_index <= scan_first;
      end else if (conv_done) begin
         scan_index <= scan_step;
      end
   end

   // multiplexer choice: A always, or A then B/A alternating
   always_ff @(posedge clk) begin
      if (rst) begin
         mux_b_select <= 1'b0;
      end else if (!alt_en) begin
         mux_b_select <= 1'b0;
      end else if (restart) begin
         mux_b_select <= 1'b0;
      end else if (conv_done) begin
         mux_b_select <= ~mux_b_select;
      end
   end

   // ---------------- interrupts ----------------
   // set wins over a write-one clear in the same cycle
   wire [1:0] irq_set   = {buf_wrap, count_done};
   wire [1:0] irq_clr   = stat_wr ? pwdata[1:0] : 2'b00;
   wire [1:0] next_stat = (irq_status & ~irq_clr) | irq_set;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= `IRQ_RESET;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_stat;
         irq        <= |(next_stat & irq_mask);
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // sequences completed since the last interrupt boundary
   logic [4:0] seq_seen;
   always_ff @(posedge clk) begin
      if (rst || ctl_wr) begin
         seq_seen <= 5'h00;
      end else if (count_done) begin
         seq_seen <= seq_done ? 5'h01 : 5'h00;
      end else if (seq_done) begin
         seq_seen <= seq_seen + 5'h01;
      end
   end

   chk_ref_both_pins: assert property (
      ref_code == 3'b011 |=> ref_high == HIGH_FROM_PIN &&
                             ref_low == LOW_FROM_PIN)
      else $error("code 011 did not select both pins");

   chk_ref_fallback: assert property (
      (ref_code[2] || ref_code == 3'b000) |=>
         ref_high == HIGH_FROM_SUPPLY && ref_low == LOW_FROM_GROUND)
      else $error("fallback code did not select supply and ground");

   chk_offset_calibration_select_route: assert property (
      offset_calibration_select_en |=> input_route == ROUTE_LOW_REF)
      else $error("calibration did not tie inputs low");

   chk_normal_route: assert property (
      !offset_calibration_select_en |=> input_route ==
         ($past(scan_en) ? ROUTE_SCAN : ROUTE_CHANNEL))
      else $error("inputs not routed by channel or scan");

   chk_scan_idle_step: assert property (
      !scan_en |-> scan_index == '0)
      else $error("scan index moved with scanning off");

   chk_scan_advance: assert property (
      scan_en && conv_done && !restart && $countones(scan_mask) > 1
      |=> scan_index != $past(scan_index) && scan_mask[scan_index])
      else $error("scan did not step to next input");

   chk_fill_tracks: assert property (
      split_en |-> fill_status == buf_addr[AW-1])
      else $error("fill status disagrees with half in use");

   chk_irq_spacing: assert property (
      count_done |-> seq_seen == {1'b0, $past(spi_limit)} + 5'h01)
      else $error("interrupt not after n+1 sequences");

   chk_half_bound: assert property (
      split_en && conv_done && !restart |=>
         buf_addr[AW-1] == $past(buf_addr[AW-1]))
      else $error("split fill crossed into other half");

   sequence s_alt_restart;
      alt_en && restart;
   endsequence

   sequence s_alt_next_conv;
      alt_en && conv_done && !restart;
   endsequence

   chk_alt_first_a: assert property (
      s_alt_restart |=> !mux_b_select)
      else $error("alternate mode did not start with A");

   chk_alt_toggle: assert property (
      s_alt_next_conv |=> mux_b_select != $past(mux_b_select))
      else $error("alternate mode did not swap setting");

   chk_alt_off: assert property (
      !alt_en [*2] |-> !mux_b_select)
      else $error("setting B used with alternate mode off");

   chk_upper_zero: assert property (
      pready |-> prdata[31:16] == 16'h0000 &&
                 (paddr != `CTL_OFFSET || (prdata[11] == 1'b0 &&
                  prdata[9:8] == 2'b00 && prdata[6] == 1'b0)))
      else $error("unimplemented bits read nonzero");

   chk_half_switch: assert property (
      split_en && count_done && !ctl_wr |=>
         fill_status != $past(fill_status) &&
         buf_addr[AW-2:0] == '0)
      else $error("count boundary did not switch halves");

   // irq follows status through the mask as it stood a cycle earlier
   chk_irq_level: assert property (
      1'b1 |=> irq == |(irq_status & $past(irq_mask)))
      else $error("irq level disagrees with status and mask");

   // a write-one clear on the boundary edge must not swallow the event
   chk_set_wins: assert property (
      count_done |=> irq_status[`IRQ_SEQ_BIT])
      else $error("sequence event lost against a clear");

endmodule : adc_sequence_buffer_control

`default_nettype wire

// ---- hdl/adc_seq_defines.svh ----
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// register byte offsets on the peripheral bus
`define CTL_OFFSET      12'h000
`define STATUS_OFFSET   12'h004
`define MASK_OFFSET     12'h008
`define SCAN_OFFSET     12'h00c

// field positions inside converter_control_two
`define REF_MSB         15
`define REF_LSB         13
`define OFFSET_CALIBRATION_SELECT_BIT      12
`define SCAN_BIT        10
`define FILL_BIT        7
`define SPI_MSB         5
`define SPI_LSB         2
`define BUFFER_MODE_SELECT_BIT        1
`define ALT_BIT         0

// reset values and the mask of software-writable bits
`define CTL_RESET       16'h0000
`define CTL_WMASK       16'hf43f
`define SCAN_RESET      16'h0000
`define IRQ_RESET       2'h0

// interrupt status bit positions
`define IRQ_SEQ_BIT     0
`define IRQ_WRAP_BIT    1

`endif

// ---- hdl/adc_seq_pkg.sv ----
`default_nettype none

package adc_seq_pkg;

   // where the high conversion reference comes from
   typedef enum logic {
      HIGH_FROM_SUPPLY = 1'b0,
      HIGH_FROM_PIN    = 1'b1
   } ref_high_t;

   // where the low conversion reference comes from
   typedef enum logic {
      LOW_FROM_GROUND = 1'b0,
      LOW_FROM_PIN    = 1'b1
   } ref_low_t;

   // what drives the sample-and-hold inputs
   typedef enum logic [1:0] {
      ROUTE_CHANNEL = 2'b00,
      ROUTE_SCAN    = 2'b01,
      ROUTE_LOW_REF = 2'b10
   } route_t;

endpackage : adc_seq_pkg

`default_nettype wire

// ---- hdl/seq_interrupt_counter.sv ----
`default_nettype none

// counts finished sample/convert sequences and pulses once per n+1
module seq_interrupt_counter #(
   parameter int CW = 4
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          clear,
   input  wire logic          seq_done,
   input  wire logic [CW-1:0] limit,
   output logic               done
);

   logic [CW-1:0] count;   // sequences seen since the last pulse

   // a limit change mid-count takes effect against the running count
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count <= '0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (seq_done) begin
            if (count == limit) begin
               count <= '0;
               done  <= 1'b1;
            end else begin
               count <= count + 1'b1;
            end
         end
      end
   end

endmodule : seq_interrupt_counter

`default_nettype wire

// ---- hdl/result_pointer.sv ----
`default_nettype none

// write address into the result buffer, single or split organisation
module result_pointer #(
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          clear,
   input  wire logic          conv_done,
   input  wire logic          split,
   input  wire logic          switch_half,
   output logic [AW-1:0]      addr,
   output logic               fill_high,
   output logic               wrap
);

   wire [AW-2:0] offs      = addr[AW-2:0];        // place inside a half
   wire          half_last = &offs;               // last word of a half
   wire          buf_last  = &addr;               // last word overall

   // a switch beats a conversion landing the same cycle
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         addr      <= '0;
         fill_high <= 1'b0;
         wrap      <= 1'b0;
      end else begin
         wrap <= 1'b0;
         if (switch_half) begin
            if (split) begin
               fill_high <= ~fill_high;
               addr      <= {~fill_high, {(AW-1){1'b0}}};
            end else begin
               addr      <= '0;
            end
         end else if (conv_done) begin
            if (split) begin
               addr <= {fill_high, offs + 1'b1};
               wrap <= half_last;
            end else begin
               addr <= addr + 1'b1;
               wrap <= buf_last;
            end
         end
      end
   end

endmodule : result_pointer

`default_nettype wire

// ---- sim/converter_model.sv ----
`default_nettype none

// stands in for the sample-and-hold and converter: one conv_done per
// result, then one seq_done; slow leaves a quiet cycle after each result
module converter_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       slow,
   input  wire logic [4:0] n_conv,
   output logic            seq_done,
   output logic            conv_done,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ps;

   // one sequence per go pulse; the quiet cycles after seq_done keep
   // conv_done off the edge where the buffer half switches
   initial begin
      seq_done  = 1'b0;
      conv_done = 1'b0;
      busy      = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            for (int i = 0; i < int'(n_conv); i++) begin
               conv_done <= 1'b1;
               @(posedge clk);
               // fast mode holds the pulse high: one result per cycle
               if (slow || i == int'(n_conv) - 1) begin
                  conv_done <= 1'b0;
                  @(posedge clk);
               end
            end
            seq_done <= 1'b1;
            @(posedge clk);
            seq_done <= 1'b0;
            repeat (3) @(posedge clk);
            busy <= 1'b0;
         end
      end
   end
endmodule : converter_model

`default_nettype wire

// ---- sim/tb.sv ----
`include "adc_seq_defines.svh"
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_seq_pkg::*;

   logic        clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        seq_done, conv_done, mux_b_select, fill_status, irq;
   logic [3:0]  scan_index, buf_addr;
   ref_high_t   ref_high;
   ref_low_t    ref_low;
   route_t      input_route;
   logic        go, slow, busy, er;
   logic [4:0]  n_conv;
   int          errors, n_tests;
   // scan mask 0x00a5 visits inputs 0, 2, 5, 7 and wraps
   logic [3:0]  scan_exp [5] = '{4'h2, 4'h5, 4'h7, 4'h0, 4'h2};

   adc_sequence_buffer_control adc_sequence_buffer_control_i (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .seq_done(seq_done),
      .conv_done(conv_done), .ref_high(ref_high), .ref_low(ref_low),
      .input_route(input_route), .scan_index(scan_index),
      .mux_b_select(mux_b_select), .buf_addr(buf_addr),
      .fill_status(fill_status), .irq(irq));

   converter_model converter_model_i (
      .clk(clk), .go(go), .slow(slow), .n_conv(n_conv),
      .seq_done(seq_done), .conv_done(conv_done), .busy(busy));

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run();
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run

   // case inequality so an unknown never counts as a match
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask : rdc

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle

   // one converter sequence of n results, waits for the model to finish
   task automatic run(input logic [4:0] n, input logic s);
      @(posedge clk);
      go     <= 1'b1;
      n_conv <= n;
      slow   <= s;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (busy === 1'b1);
   endtask : run

   // hang guard, well beyond the few hundred cycles the tests need
   initial begin
      #50000;
      errors++;
      complete_run();
   end

   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; go = 1'b0; slow = 1'b0;
      n_conv = 5'h00; errors = 0; n_tests = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(`CTL_OFFSET, 32'h0);
      wr(`CTL_OFFSET, 32'hffffffff);
      rdc(`CTL_OFFSET, 32'h0000f43f);
      // unmapped place: refused, write lost, reads zero
      wr(12'h020, 32'hffffffff);
      cmp(er, 1'b1);
      apb(1'b0, 12'h020, 32'h0);
      cmp(rd, 32'h0);
      cmp(er, 1'b1);
      // every reference code
      for (int c = 0; c < 8; c++) begin
         wr(`CTL_OFFSET, 32'(c) << 13);
         idle(2);
         cmp(ref_high, c == 1 || c == 3);
         cmp(ref_low, c == 2 || c == 3);
      end
      // calibration outranks scanning
      wr(`CTL_OFFSET, 32'h1400);
      idle(2);
      cmp(input_route, ROUTE_LOW_REF);
      wr(`CTL_OFFSET, 32'h0000);
      idle(2);
      cmp(input_route, ROUTE_CHANNEL);
      // switching scan on starts at the first set mask bit, input 5
      wr(`SCAN_OFFSET, 32'h0020);
      wr(`CTL_OFFSET, 32'h0400);
      idle(2);
      cmp(input_route, ROUTE_SCAN);
      cmp(scan_index, 4'h5);
      // scan, alternate, one 16-word buffer, 16 sequences per interrupt
      wr(`SCAN_OFFSET, 32'h00a5);
      wr(`CTL_OFFSET, 32'h043d);
      idle(2);
      cmp(mux_b_select, 1'b0);
      for (int i = 0; i < 5; i++) begin
         run(5'h01, i[0]);
         cmp(scan_index, scan_exp[i]);
         cmp(mux_b_select, !i[0]);
         cmp(buf_addr, 4'(i + 1));
      end
      for (int i = 0; i < 10; i++)
         run(5'h00, 1'b0);
      rdc(`STATUS_OFFSET, 32'h0);
      run(5'h00, 1'b0);
      rdc(`STATUS_OFFSET, 32'h1);
      cmp(irq, 1'b0);
      cmp(scan_index, 4'h0);
      cmp(mux_b_select, 1'b0);
      wr(`MASK_OFFSET, 32'h1);
      idle(2);
      cmp(irq, 1'b1);
      wr(`STATUS_OFFSET, 32'h1);
      idle(2);
      cmp(irq, 1'b0);
      // single buffer wraps after 16 results, no alternation
      wr(`CTL_OFFSET, 32'h003c);
      run(5'h10, 1'b1);
      cmp(buf_addr, 4'h0);
      cmp(fill_status, 1'b0);
      cmp(mux_b_select, 1'b0);
      rdc(`STATUS_OFFSET, 32'h2);
      cmp(irq, 1'b0);
      wr(`STATUS_OFFSET, 32'h2);
      // split buffer, interrupt every 4th sequence
      wr(`CTL_OFFSET, 32'h000e);
      for (int i = 0; i < 3; i++)
         run(5'h01, 1'b0);
      cmp(buf_addr, 4'h3);
      rdc(`CTL_OFFSET, 32'h000e);
      run(5'h01, 1'b0);
      cmp(fill_status, 1'b1);
      cmp(buf_addr, 4'h8);
      rdc(`CTL_OFFSET, 32'h008e);
      cmp(irq, 1'b1);
      wr(`STATUS_OFFSET, 32'h1);
      for (int i = 0; i < 4; i++)
         run(5'h01, 1'b0);
      cmp(fill_status, 1'b0);
      cmp(buf_addr, 4'h0);
      complete_run();
   end
endmodule : tb

`default_nettype wire
